/* File: core/owd_pkg.sv */
// constants, field layout and state type of the one-wire debug instruction engine
package owd_pkg;

    // instruction byte layout
    localparam int OP_MSB = 7;
    localparam int OP_LSB = 5;
    localparam int SIZE_A_MSB = 3;
    localparam int SIZE_A_LSB = 2;
    localparam int SIZE_B_MSB = 1;
    localparam int SIZE_B_LSB = 0;
    localparam int PTR_MSB = 3;
    localparam int PTR_LSB = 2;
    localparam int CS_ADDR_MSB = 3;
    localparam int CS_ADDR_LSB = 0;

    // opcodes
    localparam logic [2:0] OP_DIRECT_LOAD = 3'h0;
    localparam logic [2:0] OP_INDIRECT_LOAD = 3'h1;
    localparam logic [2:0] OP_DIRECT_STORE = 3'h2;
    localparam logic [2:0] OP_INDIRECT_STORE = 3'h3;
    localparam logic [2:0] OP_CONTROL_SPACE_LOAD = 3'h4;

    // pointer_mode field values
    localparam logic [1:0] PTR_AT = 2'h0;
    localparam logic [1:0] PTR_POST_INC = 2'h1;
    localparam logic [1:0] PTR_REGISTER = 2'h2;

    // response characters and reset values
    localparam logic [7:0] ACK_CHAR = 8'h40;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [23:0] ACK_PAD = 24'h00_0000;
    localparam logic [2:0] ONE_BYTE = 3'h1;
    localparam logic [2:0] CNT_ZERO = 3'h0;

    // default bus access time-out in core clock cycles
    localparam int BUS_TIMEOUT_DEFAULT = 65536;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_INSN,
        ST_ADDR,
        ST_DATA,
        ST_BUS,
        ST_CSRD,
        ST_TX,
        ST_ERROR
    } owd_state_t;

endpackage

/* File: core/owd_guard_timer.sv */
// guard interval timer: counts idle bits of the current bit period
module owd_guard_timer #(
    parameter int PERIOD_W = 16,
    parameter int GUARD_W = 8
) (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // control
    input wire logic i_start,
    input wire logic [PERIOD_W-1:0] i_bit_cycles,
    input wire logic [GUARD_W-1:0] i_guard_bits,
    // status
    output logic o_done
);

    logic [PERIOD_W-1:0] period_r;
    logic [PERIOD_W-1:0] bit_cnt_r;
    logic [GUARD_W-1:0] bits_left_r;
    logic done_r;

    generate
        if (PERIOD_W < 2 || GUARD_W < 1) begin : g_bad
            $error("owd_guard_timer: widths too small");
        end
    endgenerate

    // period latched at start so each idle bit uses the current baud
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            period_r <= '0;
            bit_cnt_r <= '0;
            bits_left_r <= '0;
            done_r <= 1'b1;
        end else if (i_ce) begin
            if (i_start) begin
                period_r <= i_bit_cycles;
                bit_cnt_r <= '0;
                bits_left_r <= i_guard_bits;
                done_r <= (i_guard_bits == '0);
            end else if (!done_r) begin
                if (bit_cnt_r + PERIOD_W'(1) >= period_r) begin
                    bit_cnt_r <= '0;
                    bits_left_r <= bits_left_r - GUARD_W'(1);
                    if (bits_left_r == GUARD_W'(1)) begin
                        done_r <= 1'b1;
                    end
                end else begin
                    bit_cnt_r <= bit_cnt_r + PERIOD_W'(1);
                end
            end
        end
    end

    assign o_done = done_r;

endmodule

/* File: core/owd_engine.sv */
// instruction layer of the one-wire debug interface: loads, stores, acks, guard time
module owd_engine #(
    parameter int PERIOD_W = 16,
    parameter int GUARD_W = 8,
    parameter int CS_ADDR_W = 4,
    parameter int BUS_TIMEOUT_CYC = owd_pkg::BUS_TIMEOUT_DEFAULT
) (
    // clock, reset, enable
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    // receive side of the serial physical layer
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    input wire logic i_rx_sync,
    input wire logic i_rx_break,
    input wire logic i_rx_err,
    input wire logic [PERIOD_W-1:0] i_bit_cycles,
    // transmit side of the serial physical layer
    output logic o_tx_valid,
    output logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    // link_control_a guard field
    input wire logic [GUARD_W-1:0] i_guard_time_count,
    // bus_access_layer request port
    output logic o_bus_req,
    output logic o_bus_we,
    output logic [31:0] o_bus_addr,
    output logic [31:0] o_bus_wdata,
    output logic [2:0] o_bus_nbytes,
    input wire logic i_bus_ack,
    input wire logic i_bus_err,
    input wire logic [31:0] i_bus_rdata,
    // access_interface_space read port
    output logic o_cs_rd,
    output logic [CS_ADDR_W-1:0] o_cs_addr,
    input wire logic [7:0] i_cs_rdata,
    // status
    output logic o_err_state,
    output logic [31:0] o_pointer
);
    localparam int TO_W = $clog2(BUS_TIMEOUT_CYC + 1);
    generate
        if (BUS_TIMEOUT_CYC < 2 || CS_ADDR_W < 1 || CS_ADDR_W > 4) begin : g_bad
            $error("owd_engine: unsupported parameter value");
        end
    endgenerate
    owd_pkg::owd_state_t state_r;
    logic [2:0] op_r;
    logic [1:0] ptr_mode_r;
    logic [2:0] size_a_r;
    logic [2:0] size_b_r;
    logic [2:0] cnt_r;
    logic [31:0] addr_r;
    logic [31:0] wdata_r;
    logic [31:0] ptr_r;
    logic [31:0] tx_buf_r;
    logic [2:0] tx_left_r;
    logic tx_valid_r;
    logic bus_req_r;
    logic bus_we_r;
    logic [31:0] bus_addr_r;
    logic [31:0] bus_wdata_r;
    logic [2:0] bus_nbytes_r;
    logic cs_rd_r;
    logic [CS_ADDR_W-1:0] cs_addr_r;
    logic err_r;
    logic guard_start_r;
    logic guard_done;
    logic [TO_W-1:0] to_cnt_r;
    logic bus_fail;
    logic [31:0] addr_full;
    logic [31:0] wdata_full;
    // size code n means n+1 bytes, so 32 bits at most
    function automatic logic [2:0] nbytes(input logic [1:0] code);
        return {1'b0, code} + 3'h1;
    endfunction
    // place a received byte, least significant first
    function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [2:0] idx, input logic [7:0] b);
        logic [31:0] r;
        r = w;
        r[idx[1:0]*8 +: 8] = b;
        return r;
    endfunction
    assign addr_full = put_byte(addr_r, cnt_r, i_rx_data);
    assign wdata_full = put_byte(wdata_r, cnt_r, i_rx_data);
    // guard starts at the last received byte and runs in parallel with bus access
    owd_guard_timer #(
        .PERIOD_W(PERIOD_W),
        .GUARD_W(GUARD_W)
    ) u_guard (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_start(guard_start_r),
        .i_bit_cycles(i_bit_cycles),
        .i_guard_bits(i_guard_time_count),
        .o_done(guard_done)
    );
    // bus access time-out bounds the idle gap
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            to_cnt_r <= '0;
        end else if (i_ce) begin
            if (state_r == owd_pkg::ST_BUS && bus_req_r) begin
                to_cnt_r <= to_cnt_r + TO_W'(1);
            end else begin
                to_cnt_r <= '0;
            end
        end
    end
    assign bus_fail = (state_r == owd_pkg::ST_BUS) && !i_bus_ack &&
                      (i_bus_err || to_cnt_r == TO_W'(BUS_TIMEOUT_CYC - 1));
    // instruction sequencer
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= owd_pkg::ST_IDLE;
            op_r <= owd_pkg::OP_DIRECT_LOAD;
            ptr_mode_r <= owd_pkg::PTR_AT;
            size_a_r <= owd_pkg::ONE_BYTE;
            size_b_r <= owd_pkg::ONE_BYTE;
            cnt_r <= owd_pkg::CNT_ZERO;
            addr_r <= owd_pkg::WORD_ZERO;
            wdata_r <= owd_pkg::WORD_ZERO;
            ptr_r <= owd_pkg::WORD_ZERO;
            tx_buf_r <= owd_pkg::WORD_ZERO;
            tx_left_r <= owd_pkg::CNT_ZERO;
            tx_valid_r <= 1'b0;
            bus_req_r <= 1'b0;
            bus_we_r <= 1'b0;
            bus_addr_r <= owd_pkg::WORD_ZERO;
            bus_wdata_r <= owd_pkg::WORD_ZERO;
            bus_nbytes_r <= owd_pkg::ONE_BYTE;
            cs_rd_r <= 1'b0;
            cs_addr_r <= '0;
            err_r <= 1'b0;
            guard_start_r <= 1'b0;
        end else if (i_ce) begin
            cs_rd_r <= 1'b0;
            guard_start_r <= 1'b0;
            if (i_rx_break) begin
                // break is the only way out of the error state
                state_r <= owd_pkg::ST_IDLE;
                err_r <= 1'b0;
                bus_req_r <= 1'b0;
                tx_valid_r <= 1'b0;
            end else if (state_r != owd_pkg::ST_ERROR && (i_rx_err || bus_fail)) begin
                state_r <= owd_pkg::ST_ERROR;
                err_r <= 1'b1;
                bus_req_r <= 1'b0;
                tx_valid_r <= 1'b0;
            end else begin
                case (state_r)
                    owd_pkg::ST_IDLE: begin
                        // each instruction follows a sync character
                        if (i_rx_sync) begin
                            state_r <= owd_pkg::ST_INSN;
                        end
                    end
                    owd_pkg::ST_INSN: begin
                        if (i_rx_valid) begin
                            op_r <= i_rx_data[owd_pkg::OP_MSB:owd_pkg::OP_LSB];
                            ptr_mode_r <= i_rx_data[owd_pkg::PTR_MSB:owd_pkg::PTR_LSB];
                            size_a_r <= nbytes(i_rx_data[owd_pkg::SIZE_A_MSB:owd_pkg::SIZE_A_LSB]);
                            size_b_r <= nbytes(i_rx_data[owd_pkg::SIZE_B_MSB:owd_pkg::SIZE_B_LSB]);
                            cnt_r <= owd_pkg::CNT_ZERO;
                            addr_r <= owd_pkg::WORD_ZERO;
                            wdata_r <= owd_pkg::WORD_ZERO;
                            bus_we_r <= 1'b0;
                            // two address spaces are reachable
                            case (i_rx_data[owd_pkg::OP_MSB:owd_pkg::OP_LSB])
                                owd_pkg::OP_DIRECT_LOAD, owd_pkg::OP_DIRECT_STORE: begin
                                    state_r <= owd_pkg::ST_ADDR;
                                end
                                owd_pkg::OP_INDIRECT_LOAD: begin
                                    guard_start_r <= 1'b1;
                                    if (i_rx_data[owd_pkg::PTR_MSB:owd_pkg::PTR_LSB] == owd_pkg::PTR_REGISTER) begin
                                        // pointer readout, same protocol
                                        tx_buf_r <= ptr_r;
                                        tx_left_r <= nbytes(i_rx_data[owd_pkg::SIZE_B_MSB:owd_pkg::SIZE_B_LSB]);
                                        state_r <= owd_pkg::ST_TX;
                                    end else begin
                                        bus_req_r <= 1'b1;
                                        bus_addr_r <= ptr_r;
                                        bus_nbytes_r <= nbytes(i_rx_data[owd_pkg::SIZE_B_MSB:owd_pkg::SIZE_B_LSB]);
                                        state_r <= owd_pkg::ST_BUS;
                                    end
                                end
                                owd_pkg::OP_INDIRECT_STORE: begin
                                    if (i_rx_data[owd_pkg::PTR_MSB:owd_pkg::PTR_LSB] == owd_pkg::PTR_REGISTER) begin
                                        // pointer mode occupies the size-A bits, address size is in bits 1:0
                                        size_a_r <= nbytes(i_rx_data[owd_pkg::SIZE_B_MSB:owd_pkg::SIZE_B_LSB]);
                                        state_r <= owd_pkg::ST_ADDR;
                                    end else begin
                                        state_r <= owd_pkg::ST_DATA;
                                    end
                                end
                                owd_pkg::OP_CONTROL_SPACE_LOAD: begin
                                    // address from operand, one byte back
                                    cs_addr_r <= i_rx_data[CS_ADDR_W-1:owd_pkg::CS_ADDR_LSB];
                                    cs_rd_r <= 1'b1;
                                    guard_start_r <= 1'b1;
                                    state_r <= owd_pkg::ST_CSRD;
                                end
                                default: begin
                                    state_r <= owd_pkg::ST_ERROR;
                                    err_r <= 1'b1;
                                end
                            endcase
                        end
                    end
                    owd_pkg::ST_ADDR: begin
                        if (i_rx_valid) begin
                            addr_r <= addr_full;
                            cnt_r <= cnt_r + 3'h1;
                            if (cnt_r + 3'h1 == size_a_r) begin
                                cnt_r <= owd_pkg::CNT_ZERO;
                                guard_start_r <= 1'b1;
                                if (op_r == owd_pkg::OP_DIRECT_LOAD) begin
                                    // address taken as sent, never advanced
                                    bus_req_r <= 1'b1;
                                    bus_addr_r <= addr_full;
                                    bus_nbytes_r <= size_b_r;
                                    state_r <= owd_pkg::ST_BUS;
                                end else begin
                                    if (op_r == owd_pkg::OP_INDIRECT_STORE) begin
                                        ptr_r <= addr_full;
                                    end
                                    // address acknowledge
                                    tx_buf_r <= {owd_pkg::ACK_PAD, owd_pkg::ACK_CHAR};
                                    tx_left_r <= owd_pkg::ONE_BYTE;
                                    state_r <= owd_pkg::ST_TX;
                                end
                            end
                        end
                    end
                    owd_pkg::ST_DATA: begin
                        if (i_rx_valid) begin
                            wdata_r <= wdata_full;
                            cnt_r <= cnt_r + 3'h1;
                            if (cnt_r + 3'h1 == size_b_r) begin
                                cnt_r <= owd_pkg::CNT_ZERO;
                                guard_start_r <= 1'b1;
                                bus_req_r <= 1'b1;
                                bus_we_r <= 1'b1;
                                bus_addr_r <= (op_r == owd_pkg::OP_DIRECT_STORE) ? addr_r : ptr_r;
                                bus_wdata_r <= wdata_full;
                                bus_nbytes_r <= size_b_r;
                                state_r <= owd_pkg::ST_BUS;
                            end
                        end
                    end
                    owd_pkg::ST_BUS: begin
                        if (i_bus_ack) begin
                            bus_req_r <= 1'b0;
                            if (ptr_mode_r == owd_pkg::PTR_POST_INC && op_r != owd_pkg::OP_DIRECT_LOAD &&
                                op_r != owd_pkg::OP_DIRECT_STORE) begin
                                ptr_r <= ptr_r + {29'h0, size_b_r};
                            end
                            if (bus_we_r) begin
                                // ack only after the write succeeded
                                tx_buf_r <= {owd_pkg::ACK_PAD, owd_pkg::ACK_CHAR};
                                tx_left_r <= owd_pkg::ONE_BYTE;
                            end else begin
                                tx_buf_r <= i_bus_rdata;
                                tx_left_r <= size_b_r;
                            end
                            state_r <= owd_pkg::ST_TX;
                        end
                    end
                    owd_pkg::ST_CSRD: begin
                        tx_buf_r <= {owd_pkg::ACK_PAD, i_cs_rdata};
                        tx_left_r <= owd_pkg::ONE_BYTE;
                        state_r <= owd_pkg::ST_TX;
                    end
                    owd_pkg::ST_TX: begin
                        if (!tx_valid_r) begin
                            // first byte waits for the guard interval
                            if (!guard_start_r && guard_done) begin
                                tx_valid_r <= 1'b1;
                            end
                        end else if (i_tx_ready) begin
                            tx_buf_r <= {8'h00, tx_buf_r[31:8]};
                            tx_left_r <= tx_left_r - 3'h1;
                            if (tx_left_r == owd_pkg::ONE_BYTE) begin
                                tx_valid_r <= 1'b0;
                                if (op_r == owd_pkg::OP_DIRECT_STORE && !bus_we_r) begin
                                    state_r <= owd_pkg::ST_DATA;
                                end else begin
                                    state_r <= owd_pkg::ST_IDLE;
                                end
                            end
                        end
                    end
                    owd_pkg::ST_ERROR: begin
                        state_r <= owd_pkg::ST_ERROR;
                    end
                    default: begin
                        state_r <= owd_pkg::ST_IDLE;
                    end
                endcase
            end
        end
    end
    assign o_tx_valid = tx_valid_r;
    assign o_tx_data = tx_buf_r[7:0];
    assign o_bus_req = bus_req_r;
    assign o_bus_we = bus_we_r;
    assign o_bus_addr = bus_addr_r;
    assign o_bus_wdata = bus_wdata_r;
    assign o_bus_nbytes = bus_nbytes_r;
    assign o_cs_rd = cs_rd_r;
    assign o_cs_addr = cs_addr_r;
    assign o_err_state = err_r;
    assign o_pointer = ptr_r;
endmodule

/* File: tb/owd_engine_checker.sv */
// assertion checker for the one-wire debug instruction engine
module owd_engine_checker #(
    parameter int PERIOD_W = 16,
    parameter int GUARD_W = 8,
    parameter int BUS_TIMEOUT_CYC = 64
) (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // serial side
    input wire logic i_rx_valid,
    input wire logic i_rx_break,
    input wire logic i_rx_err,
    input wire logic [PERIOD_W-1:0] i_bit_cycles,
    input wire logic [GUARD_W-1:0] i_guard_time_count,
    input wire logic o_tx_valid,
    input wire logic [7:0] o_tx_data,
    input wire logic i_tx_ready,
    // bus and status
    input wire logic o_bus_req,
    input wire logic [31:0] o_bus_addr,
    input wire logic i_bus_ack,
    input wire logic o_cs_rd,
    input wire logic o_err_state
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] gap_r;
    logic [31:0] req_r;
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) gap_r <= 32'h0000_0000;
        else if (i_rx_valid) gap_r <= 32'h0000_0000;
        else if (gap_r != 32'hFFFF_FFFF) gap_r <= gap_r + 32'h0000_0001;
    end
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) req_r <= 32'h0000_0000;
        else req_r <= o_bus_req ? req_r + 32'h0000_0001 : 32'h0000_0000;
    end
    guard_gap_a: assert property ($rose(o_tx_valid) |-> gap_r >= i_guard_time_count * i_bit_cycles)
        else $error("response started before guard time");
    bus_hold_a: assert property (o_bus_req && !i_bus_ack && !i_rx_break |=>
        o_err_state || (o_bus_req && $stable(o_bus_addr))) else $error("bus request not held");
    tx_hold_a: assert property (o_tx_valid && !i_tx_ready && !i_rx_break && !i_rx_err |=>
        o_tx_valid && $stable(o_tx_data)) else $error("tx byte not held");
    err_quiet_a: assert property (o_err_state |-> !o_tx_valid && !o_bus_req)
        else $error("traffic in error state");
    break_clear_a: assert property (i_rx_break |=> !o_err_state) else $error("break did not clear");
    rx_err_a: assert property (i_rx_err && !i_rx_break |=> o_err_state) else $error("rx error ignored");
    err_hold_a: assert property (o_err_state && !i_rx_break |=> o_err_state) else $error("error left");
    cs_pulse_a: assert property (o_cs_rd |=> !o_cs_rd) else $error("cs read too long");
    bus_limit_a: assert property (req_r <= BUS_TIMEOUT_CYC + 1) else $error("bus wait too long");
endmodule
bind owd_engine owd_engine_checker #(.PERIOD_W(PERIOD_W), .GUARD_W(GUARD_W), .BUS_TIMEOUT_CYC(BUS_TIMEOUT_CYC))
    owd_engine_checker_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_rx_valid(i_rx_valid),
    .i_rx_break(i_rx_break), .i_rx_err(i_rx_err), .i_bit_cycles(i_bit_cycles),
    .i_guard_time_count(i_guard_time_count), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
    .i_tx_ready(i_tx_ready), .o_bus_req(o_bus_req), .o_bus_addr(o_bus_addr), .i_bus_ack(i_bus_ack),
    .o_cs_rd(o_cs_rd), .o_err_state(o_err_state));

/* File: tb/owd_dbg_model.sv */
// debugger model: takes response bytes, promptly or after a delay
module owd_dbg_model (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    // response bytes from the engine
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    input wire logic [7:0] i_delay,
    output logic o_tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rxq[$];
    logic [7:0] cnt = 8'h00;
    initial o_tx_ready = 1'b0;
    // any idle gap is tolerated, the wait has no limit here
    always @(negedge i_core_clk) begin
        if (!i_rst_n || o_tx_ready) begin
            o_tx_ready <= 1'b0;
            cnt <= 8'h00;
        end else if (i_tx_valid) begin
            if (cnt >= i_delay) o_tx_ready <= 1'b1;
            else cnt <= cnt + 8'h01;
        end
    end
    always @(posedge i_core_clk) if (i_rst_n && i_tx_valid && o_tx_ready) rxq.push_back(i_tx_data);
endmodule

/* File: tb/test_owd_engine.sv */
// testbench of the one-wire debug instruction engine
module test_owd_engine;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_rx_valid = 1'b0, i_rx_sync = 1'b0, i_rx_break = 1'b0;
    logic i_rx_err = 1'b0, i_tx_ready, i_bus_ack = 1'b0, o_tx_valid, o_bus_req, o_bus_we, o_cs_rd, o_err_state;
    logic stall = 1'b0, berr = 1'b0, i_bus_err = 1'b0, seen_we;
    logic [7:0] i_rx_data = 8'h00, i_cs_rdata = 8'h00, o_tx_data, dly = 8'h00;
    logic [31:0] i_bus_rdata = 32'h0000_0000, o_bus_addr, o_bus_wdata, o_pointer, seen_addr, seen_data;
    logic [2:0] o_bus_nbytes, seen_n;
    logic [3:0] o_cs_addr;
    int err_total = 0, num_checks = 0, bus_wait = 0;
    always #2.5 i_core_clk = ~i_core_clk;
    owd_engine #(.BUS_TIMEOUT_CYC(64)) owd_engine_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(1'b1),
        .i_rx_valid(i_rx_valid), .i_rx_data(i_rx_data), .i_rx_sync(i_rx_sync), .i_rx_break(i_rx_break),
        .i_rx_err(i_rx_err), .i_bit_cycles(16'h0004), .o_tx_valid(o_tx_valid), .o_tx_data(o_tx_data),
        .i_tx_ready(i_tx_ready), .i_guard_time_count(8'h02), .o_bus_req(o_bus_req), .o_bus_we(o_bus_we),
        .o_bus_addr(o_bus_addr), .o_bus_wdata(o_bus_wdata), .o_bus_nbytes(o_bus_nbytes), .i_bus_ack(i_bus_ack),
        .i_bus_err(i_bus_err), .i_bus_rdata(i_bus_rdata), .o_cs_rd(o_cs_rd), .o_cs_addr(o_cs_addr),
        .i_cs_rdata(i_cs_rdata), .o_err_state(o_err_state), .o_pointer(o_pointer));
    owd_dbg_model owd_dbg_model_inst (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_tx_valid(o_tx_valid),
        .i_tx_data(o_tx_data), .i_delay(dly), .o_tx_ready(i_tx_ready));
    function automatic logic [31:0] mem_val(input logic [31:0] a);
        return a ^ 32'h5A3C_96F0;
    endfunction
    // system bus and control space responders
    always @(negedge i_core_clk) begin
        i_bus_ack <= 1'b0;
        i_bus_err <= berr && o_bus_req && !i_bus_err;
        if (o_cs_rd) i_cs_rdata <= 8'hA0 | {4'h0, o_cs_addr};
        if (o_bus_req && !i_bus_ack && !stall && !berr) begin
            if (bus_wait == 2) begin
                i_bus_ack <= 1'b1;
                i_bus_rdata <= mem_val(o_bus_addr);
                {seen_addr, seen_data, seen_n, seen_we} <= {o_bus_addr, o_bus_wdata, o_bus_nbytes, o_bus_we};
                bus_wait = 0;
            end else bus_wait++;
        end
    end
    task automatic tick(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [31:0] v, input int n);
        for (int k = 0; k < n; k++) begin
            i_rx_data = v[8*k +: 8];
            i_rx_valid = 1'b1;
            tick(1);
            i_rx_valid = 1'b0;
            tick(1);
        end
    endtask
    task automatic cmd(input logic [7:0] insn);
        i_rx_sync = 1'b1;
        tick(1);
        i_rx_sync = 1'b0;
        tick(1);
        send({24'h00_0000, insn}, 1);
    endtask
    task automatic pulse_break();
        i_rx_break = 1'b1;
        tick(1);
        i_rx_break = 1'b0;
        tick(1);
    endtask
    task automatic expect_rx(input logic [31:0] v, input int n);
        int t = 0;
        while (owd_dbg_model_inst.rxq.size() < n && t < 2000) begin
            tick(1);
            t++;
        end
        if (t == 2000) begin
            err_total++;
            test_done();
        end
        for (int k = 0; k < n; k++) chk({24'h00_0000, owd_dbg_model_inst.rxq.pop_front()}, {24'h00_0000, v[8*k +: 8]});
    endtask
    initial begin
        tick(4);
        i_rst_n = 1'b1;
        chk(o_pointer, 32'h0000_0000);
        cmd(8'h85);
        expect_rx(32'h0000_00A5, 1);
        cmd(8'h47);
        send(32'h0000_1234, 2);
        expect_rx(32'h0000_0040, 1);
        send(32'hCAFE_0001, 4);
        expect_rx(32'h0000_0040, 1);
        chk(seen_addr, 32'h0000_1234);
        chk(seen_data, 32'hCAFE_0001);
        chk({28'h000_0000, seen_we, seen_n}, 32'h0000_000C);
        for (int r = 0; r < 2; r++) begin
            dly = 8'(r * 20);
            cmd(8'h05);
            send(32'h0000_1234, 2);
            expect_rx(mem_val(32'h0000_1234), 2);
            chk(seen_addr, 32'h0000_1234);
        end
        cmd(8'h6B);
        send(32'h0000_2000, 4);
        expect_rx(32'h0000_0040, 1);
        chk(o_pointer, 32'h0000_2000);
        cmd(8'h65);
        send(32'h0000_BEEF, 2);
        expect_rx(32'h0000_0040, 1);
        chk(seen_addr, 32'h0000_2000);
        chk(o_pointer, 32'h0000_2002);
        chk(seen_data, 32'h0000_BEEF);
        cmd(8'h60);
        send(32'h0000_0077, 1);
        expect_rx(32'h0000_0040, 1);
        chk(seen_addr, 32'h0000_2002);
        chk(o_pointer, 32'h0000_2002);
        chk(seen_data, 32'h0000_0077);
        cmd(8'h20);
        expect_rx(mem_val(32'h0000_2002), 1);
        cmd(8'h2B);
        expect_rx(32'h0000_2002, 4);
        cmd(8'hE0);
        cmd(8'h84);
        tick(20);
        chk({o_err_state, 31'(owd_dbg_model_inst.rxq.size())}, 32'h8000_0000);
        pulse_break();
        i_rx_err = 1'b1;
        tick(1);
        i_rx_err = 1'b0;
        chk({31'h0000_0000, o_err_state}, 32'h0000_0001);
        pulse_break();
        berr = 1'b1;
        cmd(8'h00);
        send(32'h0000_0010, 1);
        tick(4);
        chk({31'h0000_0000, o_err_state}, 32'h0000_0001);
        berr = 1'b0;
        pulse_break();
        stall = 1'b1;
        cmd(8'h00);
        send(32'h0000_0010, 1);
        tick(80);
        chk({31'h0000_0000, o_err_state}, 32'h0000_0001);
        stall = 1'b0;
        pulse_break();
        chk({31'h0000_0000, o_err_state}, 32'h0000_0000);
        test_done();
    end
endmodule
